//--- src/hub_cfg_pkg.sv
/*
 * Shared constants and carriers for the hub's upper configuration registers:
 * maker and item text arrays, feature byte and serial-port status/command byte.
 * Assumes one 200 MHz core clock and a byte-wide register port driven by the
 * serial slave or the EEPROM loader.
 */
// How it works
// [RULE1] Maker text served at descriptor index three
// [RULE2] Item text served at descriptor index two
// [RULE3] Maker byte count equals maker length
// [RULE4] Host programs text as UTF-16 little-endian
// [RULE5] Host keeps feature bits seven..five zero
// [RULE6] Feature bit four enables link status pins
// [RULE7] Zero fused delay selects register delay field
// [RULE8] Re-enable wait is field times 200 ms
// [RULE9] Feature fields loadable by EEPROM or host
// [RULE10] Feature bit zero disables PHY spread spectrum
// [RULE11] Writing soft reset restores defaults, self-clears
// [RULE12] Soft reset only in SMBus, sets active
// [RULE13] Host reprograms registers after soft reset
// [RULE14] Entering I2C or SMBus mode sets active
// [RULE15] No upstream attach while active bit set
// [RULE16] Leaving I2C mode clears active bit
// [RULE17] SMBus host clears active to allow connect
// [RULE18] Active bit: write one clears, zero ignored
// [RULE19] Status register bits seven..two read zero
// [RULE20] Text lengths default zero, capped at 64
// [RULE21] Text byte n sits at base plus n
package hub_cfg_pkg;

    localparam logic [7:0] MAKER_TEXT_BASE = 8'h50;
    localparam logic [7:0] MAKER_TEXT_LAST = 8'h8F;
    localparam logic [7:0] ITEM_TEXT_BASE = 8'h90;
    localparam logic [7:0] ITEM_TEXT_LAST = 8'hCF;
    localparam logic [7:0] FEATURE_CFG_OFFSET = 8'hF0;
    localparam logic [7:0] SERIAL_STATUS_OFFSET = 8'hF8;

    localparam int TEXT_BYTES = 64;
    localparam logic [6:0] TEXT_MAX_LEN = 7'h40;
    localparam logic [7:0] MAKER_TEXT_INDEX = 8'h03;
    localparam logic [7:0] ITEM_TEXT_INDEX = 8'h02;

    localparam int FEAT_SSC_DIS_BIT = 0;
    localparam int FEAT_DELAY_LSB = 1;
    localparam int FEAT_DELAY_MSB = 3;
    localparam int FEAT_STS_EN_BIT = 4;
    localparam int STAT_CFG_ACTIVE_BIT = 0;
    localparam int STAT_SOFT_RST_BIT = 1;

    localparam logic [7:0] TEXT_BYTE_RESET = 8'h00;
    localparam logic [7:0] FEATURE_CFG_RESET = 8'h00;
    localparam logic CFG_ACTIVE_RESET = 1'b0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int POWER_STEP_MS = 200;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int POWER_STEP_CYCLES = POWER_STEP_MS * CLK_FREQ_KHZ;

    typedef struct packed {
        logic superspeed_link_sleep;
        logic superspeed_link_up;
        logic highspeed_link_sleep;
        logic highspeed_link_up;
    } link_status_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr_en;
        logic [7:0] wr_data;
    } reg_access_t;

    typedef struct packed {
        logic req;
        logic [7:0] index;
        logic [5:0] byte_sel;
    } text_query_t;

    typedef enum logic [1:0] {
        PWR_ON = 2'b01,
        PWR_WAIT = 2'b10
    } pwr_state_t;

endpackage

//--- src/hub_string_cfg_regs.sv
/*
 * Upper configuration register bank of the hub: maker and item text bytes,
 * feature byte, serial-port status/command byte, text descriptor lookup,
 * link status pin gating and the configuration-in-progress handshake.
 * Assumes all inputs synchronous to clk; the register port is byte wide and
 * written by the serial slave or EEPROM loader; mode levels come from the
 * serial interface front end.
 */
`timescale 1ns/1ps
module hub_string_cfg_regs #(
    parameter int POWER_STEP_CYCLES = hub_cfg_pkg::POWER_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input hub_cfg_pkg::reg_access_t reg_access,
    output logic [7:0] reg_rd_data,
    input wire logic [6:0] maker_text_length,
    input wire logic [6:0] item_text_length,
    input hub_cfg_pkg::text_query_t text_query,
    output logic text_valid,
    output logic text_present,
    output logic [6:0] text_len,
    output logic [7:0] text_data,
    input wire logic cfg_mode_i2c,
    input wire logic cfg_mode_smbus,
    output logic upstream_connect_allow,
    output logic host_iface_soft_reset,
    input hub_cfg_pkg::link_status_t link_status_in,
    output hub_cfg_pkg::link_status_t link_status_out,
    output logic [3:0] link_status_oe,
    output logic phy_ssc_disable,
    input wire logic [2:0] fused_power_reenable_delay,
    input wire logic charge_mode_change,
    output logic port_power_switch_enable,
    output logic power_reenable_wait
);
    import hub_cfg_pkg::*;

    initial begin
        if (POWER_STEP_CYCLES < 1) begin
            $error("POWER_STEP_CYCLES must be at least one");
        end
        if (int'(TEXT_MAX_LEN) > TEXT_BYTES) begin
            $error("length cap exceeds text array");
        end
    end

    // Text bytes are held here; only the lengths come from the lower bank
    logic [7:0] maker_text_byte_ff [TEXT_BYTES];
    logic [7:0] item_text_byte_ff [TEXT_BYTES];
    logic [7:0] feature_ff;
    logic cfg_active_ff;
    logic soft_rst_ff;
    logic i2c_prev_ff;
    logic smbus_prev_ff;
    logic [7:0] rd_data_ff;
    logic text_valid_ff;
    logic text_present_ff;
    logic [6:0] text_len_ff;
    logic [7:0] text_data_ff;
    link_status_t link_out_ff;

    // Address decode
    wire [7:0] addr = reg_access.addr;
    wire hit_maker = (addr >= MAKER_TEXT_BASE) && (addr <= MAKER_TEXT_LAST);
    wire hit_item = (addr >= ITEM_TEXT_BASE) && (addr <= ITEM_TEXT_LAST);
    wire hit_feature = (addr == FEATURE_CFG_OFFSET);
    wire hit_status = (addr == SERIAL_STATUS_OFFSET);
    wire [5:0] maker_slot = 6'(addr - MAKER_TEXT_BASE); // RULE21
    wire [5:0] item_slot = 6'(addr - ITEM_TEXT_BASE); // RULE21

    // Writes are dropped while the soft reset is being applied
    wire wr_ok = reg_access.wr_en && !soft_rst_ff;
    wire wr_maker = wr_ok && hit_maker;
    wire wr_item = wr_ok && hit_item;
    wire wr_feature = wr_ok && hit_feature; // RULE9
    wire wr_status = wr_ok && hit_status;

    // Configuration-in-progress set and clear sources
    wire mode_entry = (cfg_mode_i2c && !i2c_prev_ff)
        || (cfg_mode_smbus && !smbus_prev_ff); // RULE14
    wire i2c_exit = i2c_prev_ff && !cfg_mode_i2c; // RULE16
    wire host_clear = wr_status && reg_access.wr_data[STAT_CFG_ACTIVE_BIT]; // RULE18
    wire cfg_set = mode_entry || soft_rst_ff; // RULE12
    wire cfg_clear = i2c_exit || host_clear; // RULE17
    wire soft_rst_req = wr_status && reg_access.wr_data[STAT_SOFT_RST_BIT]
        && cfg_mode_smbus; // RULE12

    // Lengths above the array size are capped so no byte past the array is read
    wire [6:0] maker_len = (maker_text_length > TEXT_MAX_LEN) ? TEXT_MAX_LEN
                                                               : maker_text_length; // RULE20
    wire [6:0] item_len = (item_text_length > TEXT_MAX_LEN) ? TEXT_MAX_LEN
                                                             : item_text_length; // RULE20

    // Text descriptor lookup
    wire q_maker = (text_query.index == MAKER_TEXT_INDEX) && (maker_len != 7'h00); // RULE1
    wire q_item = (text_query.index == ITEM_TEXT_INDEX) && (item_len != 7'h00); // RULE2
    wire [6:0] q_len = q_maker ? maker_len : (q_item ? item_len : 7'h00); // RULE3
    // Bytes past the length read as zero, never as stale text
    wire q_in_range = ({1'b0, text_query.byte_sel} < q_len);
    wire [7:0] q_byte = q_maker ? maker_text_byte_ff[text_query.byte_sel]
                                : item_text_byte_ff[text_query.byte_sel];
    wire [7:0] q_data = q_in_range ? q_byte : 8'h00;

    // Register read mux
    // Reads are registered: data follows the address by one cycle
    wire [7:0] status_rd = {6'h00, soft_rst_ff, cfg_active_ff}; // RULE19
    wire [7:0] rd_mux = hit_maker ? maker_text_byte_ff[maker_slot] :
                        hit_item ? item_text_byte_ff[item_slot] :
                        hit_feature ? feature_ff :
                        hit_status ? status_rd : UNMAPPED_READ;

    wire [2:0] delay_field = feature_ff[FEAT_DELAY_MSB:FEAT_DELAY_LSB];
    // A nonzero fused delay overrides the register field
    wire [2:0] delay_sel = (fused_power_reenable_delay == 3'h0) ? delay_field
        : fused_power_reenable_delay; // RULE7
    wire sts_en = feature_ff[FEAT_STS_EN_BIT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < TEXT_BYTES; i++) begin
                maker_text_byte_ff[i] <= TEXT_BYTE_RESET;
                item_text_byte_ff[i] <= TEXT_BYTE_RESET;
            end
        end else if (soft_rst_ff) begin
            for (int i = 0; i < TEXT_BYTES; i++) begin
                maker_text_byte_ff[i] <= TEXT_BYTE_RESET; // RULE11
                item_text_byte_ff[i] <= TEXT_BYTE_RESET;
            end
        end else begin
            if (wr_maker) begin
                maker_text_byte_ff[maker_slot] <= reg_access.wr_data; // RULE21
            end
            if (wr_item) begin
                item_text_byte_ff[item_slot] <= reg_access.wr_data;
            end
        end
    end

    // Bits 7..5 are stored as written; keeping them zero is the host's job
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feature_ff <= FEATURE_CFG_RESET;
        end else if (soft_rst_ff) begin
            feature_ff <= FEATURE_CFG_RESET; // RULE11
        end else if (wr_feature) begin
            feature_ff <= reg_access.wr_data; // RULE9
        end
    end

    // Set wins over clear so a mode entry is never lost to a racing write
    // Prev flops reset low, so a mode held through reset counts as entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_active_ff <= CFG_ACTIVE_RESET;
            soft_rst_ff <= 1'b0;
            i2c_prev_ff <= 1'b0;
            smbus_prev_ff <= 1'b0;
        end else begin
            i2c_prev_ff <= cfg_mode_i2c;
            smbus_prev_ff <= cfg_mode_smbus;
            soft_rst_ff <= soft_rst_req; // RULE11
            if (cfg_set) begin
                cfg_active_ff <= 1'b1; // RULE14
            end else if (cfg_clear) begin
                cfg_active_ff <= 1'b0; // RULE18
            end
        end
    end

    // Query answers and pin levels are registered, one cycle after inputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_ff <= UNMAPPED_READ;
            text_valid_ff <= 1'b0;
            text_present_ff <= 1'b0;
            text_len_ff <= 7'h00;
            text_data_ff <= 8'h00;
            link_out_ff <= '0;
        end else begin
            rd_data_ff <= rd_mux;
            text_valid_ff <= text_query.req;
            text_present_ff <= q_maker || q_item; // RULE1
            text_len_ff <= q_len; // RULE3
            text_data_ff <= q_data; // RULE2
            link_out_ff <= sts_en ? link_status_in : '0; // RULE6
        end
    end

    power_reenable_timer #(
        .STEP_CYCLES(POWER_STEP_CYCLES)
    ) u_power_timer (
        .clk(clk),
        .resetn(resetn),
        .mode_change(charge_mode_change),
        .delay_sel(delay_sel),
        .port_power_switch_enable(port_power_switch_enable),
        .power_reenable_wait(power_reenable_wait)
    );

    // Pin enables follow the feature byte at once; pin levels lag a cycle
    assign reg_rd_data = rd_data_ff;
    assign text_valid = text_valid_ff;
    assign text_present = text_present_ff;
    assign text_len = text_len_ff;
    assign text_data = text_data_ff;
    assign upstream_connect_allow = !cfg_active_ff; // RULE15
    assign host_iface_soft_reset = soft_rst_ff;
    assign link_status_out = link_out_ff;
    assign link_status_oe = {4{sts_en}}; // RULE6
    assign phy_ssc_disable = feature_ff[FEAT_SSC_DIS_BIT]; // RULE10

    soft_rst_done_a: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        soft_rst_ff |=> !soft_rst_ff && cfg_active_ff && feature_ff == FEATURE_CFG_RESET)
        else $error("soft reset did not restore and self-clear");

    soft_rst_mode_a: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        $rose(soft_rst_ff) |-> $past(cfg_mode_smbus))
        else $error("soft reset outside SMBus mode");

    cfg_entry_set_a: assert property (@(posedge clk) disable iff (!resetn) // RULE14
        ($rose(cfg_mode_i2c) || $rose(cfg_mode_smbus)) |=> cfg_active_ff [*2])
        else $error("mode entry did not set active bit");

    connect_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        $rose(cfg_active_ff) |-> !upstream_connect_allow throughout cfg_active_ff [*1])
        else $error("upstream allowed while configuring");

    i2c_exit_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        ($fell(cfg_mode_i2c) && !$rose(cfg_mode_smbus) && !soft_rst_ff) |=> !cfg_active_ff)
        else $error("I2C exit did not clear active bit");

    write_one_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE18
        (host_clear && !cfg_set) |=> !cfg_active_ff && upstream_connect_allow)
        else $error("write one did not clear active bit");

    write_zero_keep_a: assert property (@(posedge clk) disable iff (!resetn) // RULE18
        (wr_status && !reg_access.wr_data[STAT_CFG_ACTIVE_BIT] && !cfg_set && !i2c_exit)
        |=> $stable(cfg_active_ff))
        else $error("write zero changed active bit");

    status_upper_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE19
        hit_status |=> reg_rd_data[7:2] == 6'h00)
        else $error("status upper bits not zero");

    text_len_match_a: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        (text_query.req && text_query.index == MAKER_TEXT_INDEX && maker_len != 7'h00)
        |=> text_valid && text_present && text_len == $past(maker_len))
        else $error("maker length mismatch");

    text_beyond_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE20
        (text_query.req && !q_in_range) |=> text_data == 8'h00)
        else $error("byte past length not zero");

    sts_pins_off_a: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        !sts_en ##1 !sts_en |-> link_status_out == '0 && link_status_oe == 4'h0)
        else $error("status pins driven while disabled");

    sts_pins_on_a: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        sts_en ##1 sts_en |-> link_status_out == $past(link_status_in) && link_status_oe == 4'hF)
        else $error("status pins not driven while enabled");

    item_len_match_a: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        (text_query.req && text_query.index == ITEM_TEXT_INDEX && item_len != 7'h00)
        |=> text_present && text_len == $past(item_len))
        else $error("item length mismatch");

    unknown_index_a: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        (text_query.req && text_query.index != MAKER_TEXT_INDEX
            && text_query.index != ITEM_TEXT_INDEX) |=> !text_present && text_len == 7'h00)
        else $error("unknown index answered");

    len_cap_a: assert property (@(posedge clk) disable iff (!resetn) // RULE20
        text_valid |-> text_len <= TEXT_MAX_LEN)
        else $error("text length above cap");

    maker_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE21
        wr_maker |=> maker_text_byte_ff[$past(maker_slot)] == $past(reg_access.wr_data))
        else $error("maker byte not stored at its slot");

    feature_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        wr_feature |=> feature_ff == $past(reg_access.wr_data))
        else $error("feature byte not loaded");

    ssc_follow_a: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        wr_feature |=> phy_ssc_disable == $past(reg_access.wr_data[FEAT_SSC_DIS_BIT]))
        else $error("spread spectrum disable not taken");

    soft_rst_text_a: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        soft_rst_ff |=> maker_text_byte_ff[0] == TEXT_BYTE_RESET
            && item_text_byte_ff[TEXT_BYTES-1] == TEXT_BYTE_RESET)
        else $error("soft reset left text bytes");

    // Main scenarios the bench is expected to reach
    soft_rst_c: cover property (@(posedge clk) disable iff (!resetn) soft_rst_ff);
    maker_text_c: cover property (@(posedge clk) disable iff (!resetn)
        text_valid && text_present && text_len == TEXT_MAX_LEN);
    host_clear_c: cover property (@(posedge clk) disable iff (!resetn)
        $fell(cfg_active_ff) && cfg_mode_smbus);
    absent_text_c: cover property (@(posedge clk) disable iff (!resetn)
        text_valid && !text_present);

endmodule // hub_string_cfg_regs

//--- src/power_reenable_timer.sv
/*
 * Port power re-enable timer: on a charging-mode change the power switch
 * enable drops and comes back after delay_sel steps of STEP_CYCLES each.
 * Assumes mode_change is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/1ps
module power_reenable_timer #(
    parameter int STEP_CYCLES = hub_cfg_pkg::POWER_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic mode_change,
    input wire logic [2:0] delay_sel,
    output logic port_power_switch_enable,
    output logic power_reenable_wait
);
    import hub_cfg_pkg::*;

    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    initial begin
        if (STEP_CYCLES < 1) begin
            $error("STEP_CYCLES must be at least one");
        end
    end

    pwr_state_t state_ff;
    logic [2:0] steps_ff;
    logic [CW-1:0] cyc_ff;
    logic enable_ff;

    wire step_done = (cyc_ff == STEP_LAST);
    wire wait_over = (state_ff == PWR_WAIT) && (steps_ff == 3'h0);

    // Zero steps still gives one cycle off so the switch sees an edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= PWR_ON;
            steps_ff <= 3'h0;
            cyc_ff <= '0;
            enable_ff <= 1'b1;
        end else begin
            case (state_ff)
                PWR_ON: begin
                    if (mode_change) begin
                        state_ff <= PWR_WAIT;
                        steps_ff <= delay_sel; // RULE8
                        cyc_ff <= '0;
                        enable_ff <= 1'b0;
                    end
                end
                PWR_WAIT: begin
                    if (wait_over) begin
                        state_ff <= PWR_ON;
                        enable_ff <= 1'b1;
                    end else if (step_done) begin
                        cyc_ff <= '0;
                        steps_ff <= steps_ff - 3'h1;
                    end else begin
                        cyc_ff <= cyc_ff + CW'(1);
                    end
                end
                default: begin
                    state_ff <= PWR_ON;
                    enable_ff <= 1'b1;
                end
            endcase
        end
    end

    assign port_power_switch_enable = enable_ff;
    assign power_reenable_wait = (state_ff == PWR_WAIT);

    power_off_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE8
        power_reenable_wait |-> !port_power_switch_enable)
        else $error("power enabled while waiting");

    power_zero_step_a: assert property (@(posedge clk) disable iff (!resetn) // RULE8
        (mode_change && !power_reenable_wait && delay_sel == 3'h0)
        |=> !port_power_switch_enable ##1 port_power_switch_enable)
        else $error("zero delay not one cycle off");

    power_cycle_c: cover property (@(posedge clk) disable iff (!resetn)
        $rose(port_power_switch_enable));

endmodule // power_reenable_timer

//--- tb/cfg_host_model.sv
/*
 * Behavioural serial host that configures the hub's upper register bank.
 * Assumes the bank samples its byte port on the rising clock edge; the
 * host drives at the falling edge and reads one cycle after the address.
 */
`timescale 1ns/1ps
module cfg_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rd_data,
    output hub_cfg_pkg::reg_access_t reg_access
);
    import hub_cfg_pkg::*;

    initial reg_access = '{addr: 8'h00, wr_en: 1'b0, wr_data: 8'h00};

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_access <= '{addr: a, wr_en: 1'b1, wr_data: d};
        @(negedge clk);
        // Released data lines must not keep showing the last byte
        reg_access <= '{addr: a, wr_en: 1'b0, wr_data: ~d};
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_access.addr <= a;
        @(negedge clk);
        d = reg_rd_data;
    endtask

    // Each character goes out as two bytes, low byte first
    task automatic put_text(input logic [7:0] base, input string s);
        for (int i = 0; i < s.len(); i++) begin
            write_reg(base + 8'(2 * i), s[i]);
            write_reg(base + 8'(2 * i + 1), 8'h00);
        end
    endtask

    task automatic set_feature(input logic sts, input logic [2:0] dly, input logic ssc);
        write_reg(FEATURE_CFG_OFFSET, {3'b000, sts, dly, ssc});
    endtask

    task automatic end_config();
        write_reg(SERIAL_STATUS_OFFSET, 8'h01);
    endtask
endmodule // cfg_host_model

//--- tb/hub_string_cfg_regs_tb.sv
/*
 * Self-checking bench for the upper configuration register bank.
 * Assumes the host model drives the register port; the bench drives the
 * remaining inputs at the falling edge and shortens the power step to 4.
 */
`timescale 1ns/1ps
module hub_string_cfg_regs_tb;
    import hub_cfg_pkg::*;

    localparam int STEP = 4;
    logic clk, resetn, text_valid, text_present, mode_i2c, mode_smbus;
    logic connect_ok, soft_pulse, ssc_dis, charge_change, pwr_en, pwr_wait;
    logic [7:0] reg_rd_data, text_data;
    logic [6:0] maker_len, item_len, text_len;
    logic [3:0] st_oe;
    logic [2:0] fused;
    reg_access_t reg_access;
    text_query_t text_query;
    link_status_t st_in, st_out;
    int bad_count = 0;
    int checks_done = 0;

    cfg_host_model u_host (.clk(clk), .reg_rd_data(reg_rd_data), .reg_access(reg_access));

    hub_string_cfg_regs #(.POWER_STEP_CYCLES(STEP)) u_dut (
        .clk(clk), .resetn(resetn), .reg_access(reg_access), .reg_rd_data(reg_rd_data),
        .maker_text_length(maker_len), .item_text_length(item_len),
        .text_query(text_query), .text_valid(text_valid), .text_present(text_present),
        .text_len(text_len), .text_data(text_data), .cfg_mode_i2c(mode_i2c),
        .cfg_mode_smbus(mode_smbus), .upstream_connect_allow(connect_ok),
        .host_iface_soft_reset(soft_pulse), .link_status_in(st_in),
        .link_status_out(st_out), .link_status_oe(st_oe), .phy_ssc_disable(ssc_dis),
        .fused_power_reenable_delay(fused), .charge_mode_change(charge_change),
        .port_power_switch_enable(pwr_en), .power_reenable_wait(pwr_wait)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(a, d);
        check(what, d, exp);
    endtask

    task automatic query(input logic [7:0] idx, input logic [5:0] sel, input logic [6:0] len,
                         input logic [7:0] data);
        @(negedge clk);
        text_query <= '{req: 1'b1, index: idx, byte_sel: sel};
        @(negedge clk);
        text_query.req <= 1'b0;
        check("text_valid", {7'h00, text_valid}, 8'h01);
        check("text_present", {7'h00, text_present}, {7'h00, len != 7'h00});
        check("text_len", {1'b0, text_len}, {1'b0, len});
        check("text_data", text_data, data);
    endtask

    // Counts the cycles the power switch enable stays low after one change
    task automatic power_cycle(input int exp_low);
        int low;
        low = 0;
        @(negedge clk);
        charge_change <= 1'b1;
        @(negedge clk);
        charge_change <= 1'b0;
        check("power_wait", {7'h00, pwr_wait}, 8'h01);
        while (pwr_en === 1'b0 && low < 200) begin
            low++;
            @(negedge clk);
        end
        if (low >= 200) begin
            bad_count++;
            finish_test();
        end
        check("power_low", 8'(low), 8'(exp_low));
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        maker_len = 7'h00;
        item_len = 7'h00;
        text_query = '{req: 1'b0, index: 8'h00, byte_sel: 6'h00};
        mode_i2c = 1'b0;
        mode_smbus = 1'b0;
        st_in = 4'h0;
        fused = 3'h0;
        charge_change = 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check("connect", {7'h00, connect_ok}, 8'h01);
        check("power_en", {7'h00, pwr_en}, 8'h01);
        rd_check("feature_rst", FEATURE_CFG_OFFSET, FEATURE_CFG_RESET);
        rd_check("status_rst", SERIAL_STATUS_OFFSET, 8'h00);
        rd_check("unmapped", 8'hF4, UNMAPPED_READ);
        query(MAKER_TEXT_INDEX, 6'h00, 7'h00, 8'h00);
        u_host.put_text(MAKER_TEXT_BASE, "AB");
        u_host.put_text(ITEM_TEXT_BASE, "Z");
        u_host.write_reg(MAKER_TEXT_LAST, 8'h7E);
        rd_check("maker_b2", MAKER_TEXT_BASE + 8'h02, 8'h42);
        rd_check("item_b0", ITEM_TEXT_BASE, 8'h5A);
        maker_len <= 7'h04;
        item_len <= 7'h02;
        query(MAKER_TEXT_INDEX, 6'h02, 7'h04, 8'h42);
        query(MAKER_TEXT_INDEX, 6'h04, 7'h04, 8'h00);
        query(ITEM_TEXT_INDEX, 6'h00, 7'h02, 8'h5A);
        query(8'h01, 6'h00, 7'h00, 8'h00);
        maker_len <= 7'h64;
        query(MAKER_TEXT_INDEX, 6'h3F, 7'h40, 8'h7E);
        st_in <= 4'hA;
        u_host.set_feature(1'b1, 3'h2, 1'b1);
        rd_check("feature", FEATURE_CFG_OFFSET, 8'h15);
        check("ssc_dis", {7'h00, ssc_dis}, 8'h01);
        check("sts_oe", {4'h0, st_oe}, 8'h0F);
        check("sts_out", {4'h0, st_out}, 8'h0A);
        power_cycle(2 * STEP + 1);
        fused <= 3'h1;
        power_cycle(STEP + 1);
        fused <= 3'h0;
        u_host.set_feature(1'b0, 3'h0, 1'b0);
        @(negedge clk);
        check("ssc_on", {7'h00, ssc_dis}, 8'h00);
        check("sts_oe_off", {4'h0, st_oe}, 8'h00);
        check("sts_out_off", {4'h0, st_out}, 8'h00);
        power_cycle(1);
        mode_smbus <= 1'b1;
        rd_check("smb_active", SERIAL_STATUS_OFFSET, 8'h01);
        check("connect_held", {7'h00, connect_ok}, 8'h00);
        u_host.write_reg(SERIAL_STATUS_OFFSET, 8'hFC);
        rd_check("write_zero", SERIAL_STATUS_OFFSET, 8'h01);
        u_host.end_config();
        rd_check("active_clr", SERIAL_STATUS_OFFSET, 8'h00);
        check("connect_ok", {7'h00, connect_ok}, 8'h01);
        u_host.set_feature(1'b1, 3'h5, 1'b0);
        u_host.write_reg(SERIAL_STATUS_OFFSET, 8'h02);
        check("soft_pulse", {7'h00, soft_pulse}, 8'h01);
        repeat (2) @(negedge clk);
        rd_check("feat_clr", FEATURE_CFG_OFFSET, 8'h00);
        rd_check("maker_clr", MAKER_TEXT_BASE, 8'h00);
        rd_check("soft_active", SERIAL_STATUS_OFFSET, 8'h01);
        u_host.set_feature(1'b1, 3'h5, 1'b0);
        u_host.end_config();
        mode_smbus <= 1'b0;
        u_host.write_reg(SERIAL_STATUS_OFFSET, 8'h02);
        repeat (2) @(negedge clk);
        rd_check("no_soft", FEATURE_CFG_OFFSET, 8'h1A);
        mode_i2c <= 1'b1;
        rd_check("i2c_active", SERIAL_STATUS_OFFSET, 8'h01);
        mode_i2c <= 1'b0;
        rd_check("i2c_exit", SERIAL_STATUS_OFFSET, 8'h00);
        finish_test();
    end
endmodule // hub_string_cfg_regs_tb
